// ### logic/tlv_engine_consts.svh
/*
 Constants of the TLV object transfer engine: status words, tag ranges,
 length prefixes and P2 fields. Assumes inclusion by bare name.
*/
`ifndef TLV_ENGINE_CONSTS_SVH
`define TLV_ENGINE_CONSTS_SVH

`define SW_OK          16'h9000
`define SW_MORE_RD     16'h62F1
`define SW_MORE_RD_PRO 16'h62F2
`define SW_MORE_WR     16'h63F1
`define SW_MORE_WR_PRO 16'h63F2
`define SW_BAD_DATA    16'h6A80
`define SW_NOT_FOUND   16'h6A88
`define SW_NO_USE      16'h6985
`define SW_BAD_P1P2    16'h6A86
`define SW_NO_ACCESS   16'h6982
`define SW_BAD_LEN     16'h6700

`define TAG_LIST     8'h5C
`define TAG_P1_LO    8'h80
`define TAG_P1_HI    8'h9E
`define TAG_C1_LO    8'hA0
`define TAG_C1_HI    8'hBE
`define TAG_P_EXT    8'h9F
`define TAG_C_EXT    8'hBF
`define TAG2_LO      8'h1F
`define TAG_LAST_HI  8'h7F
`define TAG3_MID_LO  8'h81
`define TAG_N_1      2'h1
`define TAG_N_2      2'h2
`define TAG_N_3      2'h3

`define LEN_SHORT_MAX 8'h7F
`define LEN_1B        8'h81
`define LEN_2B        8'h82
`define LEN_3B        8'h83
`define LEN_1B_MIN    8'h80
`define LEN_1B_MAX    24'h00_00FF
`define LEN_2B_MIN    16'h0100
`define LEN_2B_MAX    24'h00_FFFF
`define LEN_3B_MIN    24'h01_0000
`define LEN_N_1       3'h1
`define LEN_N_2       3'h2
`define LEN_N_3       3'h3
`define LEN_N_4       3'h4

`define P2_BLK_HI 7
`define P2_BLK_LO 6
`define P2_SFI_HI 4
`define P2_SFI_LO 0
`define P2_FIRST  2'h2
`define P2_NEXT   2'h0
`define P2_RETX   2'h1

`endif

// ### logic/tlv_if.sv
/*
 Carrier between the engine and its tag checker and length codec.
 Assumes purely combinational leaves on the same clock.
*/
`timescale 1ns/1ps
interface tlv_if;
    logic [23:0] tag;
    logic        tag_ok;
    logic [31:0] dec_in;
    logic [23:0] dec_val;
    logic        dec_ok;
    logic [23:0] enc_val;
    logic [31:0] enc_out;
    logic [2:0]  enc_n;
    modport eng (output tag, dec_in, enc_val,
                 input tag_ok, dec_val, dec_ok, enc_out, enc_n);
    modport chk (input tag, output tag_ok);
    modport codec (input dec_in, enc_val,
                   output dec_val, dec_ok, enc_out, enc_n);
endinterface : tlv_if

// ### logic/tlv_len_codec.sv
/*
 Decodes a received length field with a minimality check and encodes an
 object length in the shortest form. Assumes field left-aligned in 32 bits.
*/
`timescale 1ns/1ps
`include "tlv_engine_consts.svh"
module tlv_len_codec (
    tlv_if.codec l
);
    logic [7:0] pfx;
    logic [23:0] v;

    always_comb begin
        pfx = l.dec_in[31:24];
        l.dec_val = 24'h00_0000;
        l.dec_ok = 1'b0;
        if (pfx <= `LEN_SHORT_MAX) begin
            l.dec_val = {16'h0000, pfx};
            l.dec_ok = 1'b1;
        end else if (pfx == `LEN_1B) begin
            l.dec_val = {16'h0000, l.dec_in[23:16]};
            l.dec_ok = l.dec_in[23:16] >= `LEN_1B_MIN;
        end else if (pfx == `LEN_2B) begin
            l.dec_val = {8'h00, l.dec_in[23:8]};
            l.dec_ok = l.dec_in[23:8] >= `LEN_2B_MIN;
        end else if (pfx == `LEN_3B) begin
            l.dec_val = l.dec_in[23:0];
            l.dec_ok = l.dec_in[23:0] >= `LEN_3B_MIN;
        end
    end

    // Shortest form always, whatever the store keeps internally
    always_comb begin
        v = l.enc_val;
        if (v <= {16'h0000, `LEN_SHORT_MAX}) begin
            l.enc_out = {v[7:0], 24'h00_0000};
            l.enc_n = `LEN_N_1;
        end else if (v <= `LEN_1B_MAX) begin
            l.enc_out = {`LEN_1B, v[7:0], 16'h0000};
            l.enc_n = `LEN_N_2;
        end else if (v <= `LEN_2B_MAX) begin
            l.enc_out = {`LEN_2B, v[15:0], 8'h00};
            l.enc_n = `LEN_N_3;
        end else begin
            l.enc_out = {`LEN_3B, v};
            l.enc_n = `LEN_N_4;
        end
    end
endmodule : tlv_len_codec

// ### logic/tlv_object_transfer_engine.sv
/*
 Card-side engine for segmented store and retrieval of TLV objects.
 Assumes an APDU front end that presents one decoded command per cycle
 and an object store that answers lookups in the same cycle.
*/
`timescale 1ns/1ps
`include "tlv_engine_consts.svh"
module tlv_object_transfer_engine
    import tlv_pkg::*;
#(
    parameter int NCH = 4,
    parameter int CW  = (NCH > 1) ? $clog2(NCH) : 1
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_cmd_valid,
    input  wire logic [CW-1:0]     i_cmd_chan,
    input  wire logic              i_cmd_store,
    input  wire logic [7:0]        i_cmd_p2,
    input  wire logic [23:0]       i_cmd_tag,
    input  wire logic [31:0]       i_cmd_lenb,
    input  wire logic [7:0]        i_cmd_seg,
    input  wire logic [8:0]        i_cmd_le,
    input  wire logic              i_pro_pend,
    input  wire logic              i_obj_found,
    input  wire logic [23:0]       i_obj_len,
    input  wire logic              i_read_ok,
    input  wire logic              i_update_ok,
    input  wire logic              i_abort,
    input  wire logic [CW-1:0]     i_abort_chan,
    output logic                   o_rsp_valid,
    output logic [15:0]            o_rsp_sw,
    output logic [CW-1:0]          o_rsp_chan,
    output logic [23:0]            o_rsp_tag,
    output logic                   o_rsp_hdr,
    output logic [31:0]            o_rsp_lenb,
    output logic [2:0]             o_rsp_lenn,
    output logic [23:0]            o_rsp_off,
    output logic [8:0]             o_rsp_cnt,
    output logic                   o_rsp_commit,
    output logic                   o_rsp_list,
    output logic [NCH-1:0]         o_rsp_pend,
    output logic [NCH-1:0]         o_pend_mask,
    output logic [NCH*24-1:0]      o_pend_tags
);

    localparam int TW = 24;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel transfer context

    logic [NCH-1:0] act;
    logic [NCH-1:0] st;
    logic [NCH-1:0] done;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] pok;
    logic [NCH-1:0] phdr;
    logic [23:0]    tg   [NCH];
    logic [23:0]    off  [NCH];
    logic [23:0]    olen [NCH];
    logic [23:0]    poff [NCH];
    logic [8:0]     pcnt [NCH];

    ////////////////////////////////////////////////////////////////////////
    // Decision signals

    tlv_if          tif ();
    blk_t           blk;
    logic           sfi0;
    logic           acc;
    logic           conf;
    logic           is_list;
    logic [23:0]    rem;
    logic [8:0]     seg9;
    logic [15:0]    more;
    logic           ok;
    logic [15:0]    next_sw;
    logic [23:0]    next_roff;
    logic [8:0]     next_cnt;
    logic           next_hdr;
    logic           next_commit;
    logic           next_list;
    logic [23:0]    next_off;
    logic [23:0]    next_len;
    logic           next_done;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic blk_t blk_of(input logic [7:0] p2);
        blk_t b;
        unique case (p2[`P2_BLK_HI:`P2_BLK_LO])
            `P2_FIRST: b = BLK_FIRST;
            `P2_NEXT:  b = BLK_NEXT;
            `P2_RETX:  b = BLK_RETX;
            default:   b = BLK_RFU;
        endcase
        return b;
    endfunction : blk_of

    // Segment size bounded by both Le and what is left of the object
    function automatic logic [8:0] clip(input logic [8:0]  le,
                                        input logic [23:0] left);
        logic [8:0] r;
        r = (left < {15'h0000, le}) ? left[8:0] : le;
        return r;
    endfunction : clip

    tlv_tag_check u_tag (
        .t (tif.chk)
    );

    tlv_len_codec u_len (
        .l (tif.codec)
    );

    assign tif.tag     = i_cmd_tag;
    assign tif.dec_in  = i_cmd_lenb;
    assign tif.enc_val = i_obj_len;

    ////////////////////////////////////////////////////////////////////////
    // Command decision

    always_comb begin
        blk  = blk_of(i_cmd_p2);
        sfi0 = i_cmd_p2[`P2_SFI_HI:`P2_SFI_LO] == 5'h00;
        acc  = i_cmd_store ? i_update_ok : i_read_ok;
        is_list = i_cmd_tag == {16'h0000, `TAG_LIST};
        rem  = olen[i_cmd_chan] - off[i_cmd_chan];
        seg9 = {1'h0, i_cmd_seg};
        if (i_cmd_store) begin
            more = i_pro_pend ? `SW_MORE_WR_PRO : `SW_MORE_WR;
        end else begin
            more = i_pro_pend ? `SW_MORE_RD_PRO : `SW_MORE_RD;
        end
        // Another channel holding this object blocks it unless both only read
        conf = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            if ((c != int'(i_cmd_chan)) && act[c] && (tg[c] == i_cmd_tag)
                && (st[c] || i_cmd_store)) begin
                conf = 1'b1;
            end
        end
        ok          = 1'b0;
        next_sw     = `SW_BAD_P1P2;
        next_roff   = off[i_cmd_chan];
        next_cnt    = 9'h000;
        next_hdr    = 1'b0;
        next_commit = 1'b0;
        next_list   = 1'b0;
        next_off    = off[i_cmd_chan];
        next_len    = olen[i_cmd_chan];

        if ((blk == BLK_RFU) || ((blk != BLK_FIRST) && !sfi0)) begin
            next_sw = `SW_BAD_P1P2;
        end else if (!acc) begin
            next_sw = `SW_NO_ACCESS;
        end else if (blk == BLK_FIRST) begin
            if (!i_cmd_store && is_list) begin
                // List object is built by the store; pending tags added
                ok        = 1'b1;
                next_list = 1'b1;
                next_hdr  = 1'b1;
                next_roff = 24'h00_0000;
                next_cnt  = clip(i_cmd_le, i_obj_len);
                next_len  = i_obj_len;
                next_off  = {15'h0000, next_cnt};
            end else if (!tif.tag_ok) begin
                next_sw = `SW_BAD_DATA;
            end else if (conf) begin
                next_sw = `SW_NO_USE;
            end else if (i_cmd_store) begin
                if (!tif.dec_ok) begin
                    next_sw = `SW_BAD_DATA;
                end else if ({16'h0000, i_cmd_seg} > tif.dec_val) begin
                    next_sw = `SW_BAD_LEN;
                end else begin
                    ok          = 1'b1;
                    next_commit = 1'b1;
                    next_roff   = 24'h00_0000;
                    next_cnt    = seg9;
                    next_len    = tif.dec_val;
                    next_off    = {16'h0000, i_cmd_seg};
                end
            end else if (!i_obj_found) begin
                next_sw = `SW_NOT_FOUND;
            end else begin
                ok        = 1'b1;
                next_hdr  = 1'b1;
                next_roff = 24'h00_0000;
                next_cnt  = clip(i_cmd_le, i_obj_len);
                next_len  = i_obj_len;
                next_off  = {15'h0000, next_cnt};
            end
        end else if (!act[i_cmd_chan] || (st[i_cmd_chan] != i_cmd_store)) begin
            next_sw = `SW_NO_USE;
        end else if (blk == BLK_NEXT) begin
            if (done[i_cmd_chan]) begin
                next_sw = `SW_BAD_P1P2;
            end else if (i_cmd_store) begin
                if ({16'h0000, i_cmd_seg} > rem) begin
                    next_sw = `SW_BAD_LEN;
                end else begin
                    ok          = 1'b1;
                    next_commit = 1'b1;
                    next_cnt    = seg9;
                    next_off    = off[i_cmd_chan] + {16'h0000, i_cmd_seg};
                end
            end else begin
                ok       = 1'b1;
                next_cnt = clip(i_cmd_le, rem);
                next_off = off[i_cmd_chan] + {15'h0000, next_cnt};
            end
        end else if (!pok[i_cmd_chan]) begin
            next_sw = `SW_NO_USE;
        end else if (i_cmd_store) begin
            // Rewrite the previous block in place
            if ({16'h0000, i_cmd_seg} > (olen[i_cmd_chan] - poff[i_cmd_chan]))
            begin
                next_sw = `SW_BAD_LEN;
            end else begin
                ok          = 1'b1;
                next_commit = 1'b1;
                next_roff   = poff[i_cmd_chan];
                next_cnt    = seg9;
                next_off    = poff[i_cmd_chan] + {16'h0000, i_cmd_seg};
            end
        end else begin
            ok        = 1'b1;
            next_roff = poff[i_cmd_chan];
            next_cnt  = pcnt[i_cmd_chan];
            next_hdr  = phdr[i_cmd_chan];
        end

        next_done = next_off == next_len;
        if (ok) begin
            next_sw = next_done ? `SW_OK : more;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel context update

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            act  <= '0;
            st   <= '0;
            done <= '0;
            pend <= '0;
            pok  <= '0;
            phdr <= '0;
            for (int c = 0; c < NCH; c++) begin
                tg[c]   <= 24'h00_0000;
                off[c]  <= 24'h00_0000;
                olen[c] <= 24'h00_0000;
                poff[c] <= 24'h00_0000;
                pcnt[c] <= 9'h000;
            end
        end else begin
            if (i_cmd_valid) begin
                pok[i_cmd_chan] <= ok;
                // Errors leave pointer and offset as they were
                if (ok) begin
                    act[i_cmd_chan]  <= 1'b1;
                    st[i_cmd_chan]   <= i_cmd_store;
                    done[i_cmd_chan] <= next_done;
                    pend[i_cmd_chan] <= i_cmd_store && !next_done
                                        && !next_list;
                    off[i_cmd_chan]  <= next_off;
                    olen[i_cmd_chan] <= next_len;
                    poff[i_cmd_chan] <= next_roff;
                    pcnt[i_cmd_chan] <= next_cnt;
                    phdr[i_cmd_chan] <= next_hdr;
                    if (blk == BLK_FIRST) begin
                        tg[i_cmd_chan] <= i_cmd_tag;
                    end
                end
            end
            // Abort applied last, so it wins over a same-cycle command
            if (i_abort) begin
                act[i_abort_chan]  <= 1'b0;
                pend[i_abort_chan] <= 1'b0;
                done[i_abort_chan] <= 1'b0;
                pok[i_abort_chan]  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response register

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_rsp_valid  <= 1'b0;
            o_rsp_sw     <= `SW_OK;
            o_rsp_chan   <= '0;
            o_rsp_tag    <= 24'h00_0000;
            o_rsp_hdr    <= 1'b0;
            o_rsp_lenb   <= 32'h0000_0000;
            o_rsp_lenn   <= 3'h0;
            o_rsp_off    <= 24'h00_0000;
            o_rsp_cnt    <= 9'h000;
            o_rsp_commit <= 1'b0;
            o_rsp_list   <= 1'b0;
            o_rsp_pend   <= '0;
        end else begin
            o_rsp_valid  <= i_cmd_valid;
            o_rsp_commit <= i_cmd_valid && next_commit;
            if (i_cmd_valid) begin
                o_rsp_sw   <= next_sw;
                o_rsp_chan <= i_cmd_chan;
                o_rsp_tag  <= ok ? ((blk == BLK_FIRST) ? i_cmd_tag
                                    : tg[i_cmd_chan]) : i_cmd_tag;
                o_rsp_hdr  <= ok && next_hdr;
                o_rsp_lenb <= tif.enc_out;
                o_rsp_lenn <= tif.enc_n;
                o_rsp_off  <= next_roff;
                o_rsp_cnt  <= ok ? next_cnt : 9'h000;
                o_rsp_list <= ok && next_list;
                // Other channels' unfinished stores join the list
                o_rsp_pend <= (ok && next_list)
                    ? (pend & ~(NCH'(1) << i_cmd_chan)) : '0;
            end
        end
    end

    assign o_pend_mask = pend;

    for (genvar c = 0; c < NCH; c++) begin : g_pend
        assign o_pend_tags[c*TW +: TW] = tg[c];
    end

endmodule : tlv_object_transfer_engine

// ### logic/tlv_pkg.sv
/*
 Types shared by the TLV object transfer engine.
 Assumes nothing of its surroundings.
*/
package tlv_pkg;
    typedef enum logic [1:0] {
        BLK_NEXT,
        BLK_RETX,
        BLK_FIRST,
        BLK_RFU
    } blk_t;
endpackage : tlv_pkg

// ### logic/tlv_tag_check.sv
/*
 Checks a right-aligned tag of one to three bytes against the
 context-specific ranges. Assumes leading unused bytes are zero.
*/
`timescale 1ns/1ps
`include "tlv_engine_consts.svh"
module tlv_tag_check (
    tlv_if.chk t
);
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
    logic       ext2;
    logic       ext3;

    always_comb begin
        b2 = t.tag[23:16];
        b1 = t.tag[15:8];
        b0 = t.tag[7:0];
        ext2 = (b1 == `TAG_P_EXT) || (b1 == `TAG_C_EXT);
        ext3 = (b2 == `TAG_P_EXT) || (b2 == `TAG_C_EXT);
        if (b2 != 8'h00) begin
            t.tag_ok = ext3 && (b1 >= `TAG3_MID_LO)
                && (b0 <= `TAG_LAST_HI);
        end else if (b1 != 8'h00) begin
            t.tag_ok = ext2 && (b0 >= `TAG2_LO)
                && (b0 <= `TAG_LAST_HI);
        end else begin
            t.tag_ok = ((b0 >= `TAG_P1_LO) && (b0 <= `TAG_P1_HI))
                || ((b0 >= `TAG_C1_LO) && (b0 <= `TAG_C1_HI));
        end
    end
endmodule : tlv_tag_check

// ### test/apdu_terminal.sv
/* Terminal model: sends one command APDU and waits its answer.
   Assumes the engine answers exactly one cycle after taking it. */
`timescale 1ns/1ps
module apdu_terminal (
    input  wire logic   i_clk,
    output logic        o_valid,
    output logic [1:0]  o_chan,
    output logic        o_store,
    output logic [7:0]  o_p2,
    output logic [23:0] o_tag,
    output logic [31:0] o_lenb,
    output logic [7:0]  o_seg,
    output logic [8:0]  o_le
);
    initial begin
        {o_valid, o_chan, o_store, o_p2, o_tag, o_lenb, o_seg, o_le} = '0;
    end
    // Caller picks unused tags, current file after first block
    // retransmit only after success, plain block after pending flag
    task send(input logic [1:0] ch, input logic st, input logic [7:0] p2,
              input logic [23:0] tg, input logic [31:0] lb,
              input logic [7:0] sg, input logic [8:0] le);
        @(posedge i_clk);
        o_valid <= 1'b1;
        {o_chan, o_store, o_p2, o_tag} <= {ch, st, p2, tg};
        {o_lenb, o_seg, o_le} <= {lb, sg, le};
        @(posedge i_clk);
        o_valid <= 1'b0;
        // Stale tag and length inverted so they differ from the ones just sent
        {o_tag, o_lenb} <= ~{tg, lb};
        #1;
    endtask : send
endmodule : apdu_terminal

// ### test/testbench.sv
/* Self-checking bench for the TLV transfer engine.
   Assumes the terminal model and the bound checker. */
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst_b = 0, pro = 0, found = 0, rd_ok = 1, abrt = 0;
    logic [23:0] olen = 0;
    logic [1:0] c_chan, abrt_chan = 0;
    logic c_valid, c_store, rsp_valid, rsp_hdr, rsp_commit, rsp_list;
    logic [7:0] c_p2, c_seg;
    logic [8:0] c_le, rsp_cnt;
    logic [15:0] rsp_sw;
    logic [23:0] c_tag, rsp_off;
    logic [31:0] c_lenb, rsp_lenb;
    logic [2:0] rsp_lenn;
    logic [3:0] pend_mask, rsp_pend;
    logic [1:0] rsp_chan;
    logic [23:0] rsp_tag;
    logic [95:0] pend_tags;
    int num_errors = 0, checked = 0;
    always #4 clk = ~clk;
    apdu_terminal apdu_terminal_inst (.i_clk(clk), .o_valid(c_valid),
        .o_chan(c_chan), .o_store(c_store), .o_p2(c_p2), .o_tag(c_tag),
        .o_lenb(c_lenb), .o_seg(c_seg), .o_le(c_le));
    tlv_object_transfer_engine #(.NCH(4)) tlv_object_transfer_engine_inst (
        .i_clk(clk), .i_rst_b(rst_b), .i_cmd_valid(c_valid),
        .i_cmd_chan(c_chan), .i_cmd_store(c_store), .i_cmd_p2(c_p2),
        .i_cmd_tag(c_tag), .i_cmd_lenb(c_lenb), .i_cmd_seg(c_seg),
        .i_cmd_le(c_le), .i_pro_pend(pro), .i_obj_found(found),
        .i_obj_len(olen), .i_read_ok(rd_ok), .i_update_ok(1'b1),
        .i_abort(abrt), .i_abort_chan(abrt_chan), .o_rsp_valid(rsp_valid),
        .o_rsp_sw(rsp_sw), .o_rsp_chan(rsp_chan), .o_rsp_tag(rsp_tag),
        .o_rsp_hdr(rsp_hdr),
        .o_rsp_lenb(rsp_lenb), .o_rsp_lenn(rsp_lenn), .o_rsp_off(rsp_off),
        .o_rsp_cnt(rsp_cnt), .o_rsp_commit(rsp_commit),
        .o_rsp_list(rsp_list), .o_rsp_pend(rsp_pend), .o_pend_mask(pend_mask),
        .o_pend_tags(pend_tags));
    ////////////////////////////////////////////////////////////////////////
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task rsp(input logic [15:0] s, input logic [23:0] o, input logic [8:0] c);
        cmp("valid", 1, rsp_valid);
        cmp("sw", s, rsp_sw);
        cmp("off", o, rsp_off);
        cmp("cnt", c, rsp_cnt);
    endtask : rsp
    task err(input logic [15:0] s);
        cmp("valid", 1, rsp_valid);
        cmp("sw", s, rsp_sw);
        cmp("cnt", 0, rsp_cnt);
    endtask : err
    task env(input logic f, input logic [23:0] n, input logic p);
        @(posedge clk);
        {found, olen, pro} <= {f, n, p};
    endtask : env
    ////////////////////////////////////////////////////////////////////////
    task t_retrieve;
        env(1, 20, 0);
        apdu_terminal_inst.send(0, 0, 8'h80, 24'h83, 0, 0, 10);
        rsp(16'h62F1, 0, 10);
        cmp("hdr", 1, rsp_hdr);
        cmp("lenb", 32'h1400_0000, rsp_lenb);
        apdu_terminal_inst.send(3, 0, 8'h80, 24'h84, 0, 0, 5);
        rsp(16'h62F1, 0, 5);
        cmp("chan", 3, rsp_chan);
        apdu_terminal_inst.send(0, 0, 8'h80, 24'h83, 0, 0, 5);
        rsp(16'h62F1, 0, 5);
        apdu_terminal_inst.send(0, 0, 8'h00, 0, 0, 0, 10);
        rsp(16'h62F1, 5, 10);
        cmp("tag", 24'h83, rsp_tag);
        apdu_terminal_inst.send(0, 0, 8'h00, 0, 0, 0, 10);
        rsp(16'h9000, 15, 5);
        apdu_terminal_inst.send(0, 0, 8'h00, 0, 0, 0, 10);
        err(16'h6A86);
    endtask : t_retrieve
    task t_proretx;
        env(1, 300, 1);
        apdu_terminal_inst.send(1, 0, 8'h80, 24'h9F1F, 0, 0, 100);
        rsp(16'h62F2, 0, 100);
        cmp("lenb", 32'h8201_2C00, rsp_lenb);
        cmp("lenn", 3, rsp_lenn);
        apdu_terminal_inst.send(1, 0, 8'h40, 0, 0, 0, 100);
        rsp(16'h62F2, 0, 100);
        apdu_terminal_inst.send(1, 0, 8'h00, 0, 0, 0, 100);
        rsp(16'h62F2, 100, 100);
        apdu_terminal_inst.send(1, 0, 8'h01, 0, 0, 0, 100);
        err(16'h6A86);
        apdu_terminal_inst.send(1, 0, 8'h00, 0, 0, 0, 100);
        rsp(16'h9000, 200, 100);
    endtask : t_proretx
    task t_tags;
        logic [23:0] tg [10] = '{24'h7F, 24'h9F, 24'h9F1E, 24'h9F8180,
            24'hC0, 24'h80, 24'h9E, 24'hBF7F, 24'h9FFF7F, 24'hBF8100};
        env(0, 0, 0);
        for (int i = 0; i < 10; i++) begin
            apdu_terminal_inst.send(2, 0, 8'h80, tg[i], 0, 0, 1);
            err(i < 5 ? 16'h6A80 : 16'h6A88);
        end
        env(1, 6, 0);
        apdu_terminal_inst.send(2, 0, 8'h80, 24'h5C, 0, 0, 50);
        rsp(16'h9000, 0, 6);
        cmp("list", 1, rsp_list);
        @(posedge clk);
        rd_ok <= 0;
        apdu_terminal_inst.send(2, 0, 8'h80, 24'h85, 0, 0, 1);
        err(16'h6982);
        rd_ok <= 1;
    endtask : t_tags
    task t_store;
        env(0, 0, 0);
        apdu_terminal_inst.send(2, 1, 8'h80, 24'hA1, 32'h0500_0000, 3, 0);
        rsp(16'h63F1, 0, 3);
        cmp("commit", 1, rsp_commit);
        cmp("pend", 1, pend_mask[2]);
        cmp("ptag", 24'hA1, pend_tags[71:48]);
        apdu_terminal_inst.send(0, 0, 8'h80, 24'h5C, 0, 0, 9);
        cmp("lpend", 4'b0100, rsp_pend);
        env(1, 5, 0);
        apdu_terminal_inst.send(1, 0, 8'h80, 24'hA1, 0, 0, 9);
        err(16'h6985);
        apdu_terminal_inst.send(2, 1, 8'h00, 0, 0, 3, 0);
        err(16'h6700);
        apdu_terminal_inst.send(2, 1, 8'h00, 0, 0, 2, 0);
        rsp(16'h9000, 3, 2);
        apdu_terminal_inst.send(0, 1, 8'h80, 24'hA2, 32'h8105_0000, 0, 0);
        err(16'h6A80);
        env(0, 0, 0);
        apdu_terminal_inst.send(3, 1, 8'h80, 24'hA3, 32'h0400_0000, 1, 0);
        rsp(16'h63F1, 0, 1);
        @(posedge clk);
        abrt <= 1;
        abrt_chan <= 3;
        @(posedge clk);
        abrt <= 0;
        apdu_terminal_inst.send(3, 1, 8'h00, 0, 0, 1, 0);
        err(16'h6985);
    endtask : t_store
    task give_verdict;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge clk);
        cmp("reset sw", 16'h9000, rsp_sw);
        rst_b <= 1;
        t_retrieve;
        t_proretx;
        t_tags;
        t_store;
        give_verdict;
    end
endmodule : testbench

// ### test/tlv_engine_checker.sv
/* Timing and status checks on the engine's ports.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module tlv_engine_checker (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_store,
    input  wire logic [7:0]  i_cmd_p2,
    input  wire logic        i_pro_pend,
    input  wire logic        i_read_ok,
    input  wire logic        i_abort,
    input  wire logic        o_rsp_valid,
    input  wire logic [15:0] o_rsp_sw,
    input  wire logic        o_rsp_hdr,
    input  wire logic [23:0] o_rsp_off,
    input  wire logic [8:0]  o_rsp_cnt,
    input  wire logic        o_rsp_commit
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    sequence s_rd;
        i_cmd_valid && !i_cmd_store && !i_abort;
    endsequence
    // More-data codes 62xx/63xx are not errors
    sequence s_err;
        o_rsp_valid && o_rsp_sw[15:12] == 4'h6 && o_rsp_sw[11:9] != 3'h1;
    endsequence
    AST_ANSWER: assert property (i_cmd_valid |=> o_rsp_valid)
        else $error("command not answered");
    AST_NO_EXTRA: assert property (!i_cmd_valid |=> !o_rsp_valid)
        else $error("answer without command");
    AST_RSVD: assert property (i_cmd_valid && i_cmd_p2[7:6] == 2'b11
        |=> o_rsp_sw == 16'h6A86) else $error("reserved block accepted");
    AST_READ: assert property (s_rd ##0 i_cmd_p2[7:6] == 2'b10
        && !i_read_ok |=> o_rsp_sw == 16'h6982) else $error("read denied");
    AST_PRO: assert property (s_rd ##0 i_pro_pend
        |=> o_rsp_sw != 16'h62F1) else $error("pending flag lost");
    AST_NOPRO: assert property (s_rd ##0 !i_pro_pend
        |=> o_rsp_sw != 16'h62F2) else $error("pending flag invented");
    AST_ERR_CNT: assert property (s_err
        |-> o_rsp_cnt == 9'h000 && !o_rsp_commit) else $error("error moved");
    AST_HDR: assert property (o_rsp_valid && o_rsp_hdr
        |-> o_rsp_off == 24'h00_0000) else $error("header not at start");
    AST_COMMIT: assert property (o_rsp_commit |-> $past(i_cmd_store)
        && o_rsp_sw inside {16'h9000, 16'h63F1, 16'h63F2})
        else $error("bad commit");
endmodule : tlv_engine_checker
bind tlv_object_transfer_engine tlv_engine_checker tlv_engine_checker_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_valid(i_cmd_valid),
    .i_cmd_store(i_cmd_store), .i_cmd_p2(i_cmd_p2), .i_pro_pend(i_pro_pend),
    .i_read_ok(i_read_ok), .i_abort(i_abort), .o_rsp_valid(o_rsp_valid),
    .o_rsp_sw(o_rsp_sw), .o_rsp_hdr(o_rsp_hdr), .o_rsp_off(o_rsp_off),
    .o_rsp_cnt(o_rsp_cnt), .o_rsp_commit(o_rsp_commit));
